// >>> hdl/arith_slice_carry_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "arith_slice_defines.svh"
module arith_slice_carry_select
  import arith_slice_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic inRange(input start_t start, input int idx);
    inRange = (int'(start) <= idx);
  endfunction : inRange

  function automatic logic isStart(input start_t start, input int idx);
    isStart = (int'(start) == idx);
  endfunction : isStart

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  word_t       opA_q;
  word_t       opA_d;
  word_t       opB_q;
  word_t       opB_d;
  word_t       load_q;
  word_t       load_d;
  word_t       pairSel_q;
  word_t       pairSel_d;
  logic [3:0]  cmd_q;
  logic [3:0]  cmd_d;
  bus_state_t  bus_q;
  bus_state_t  bus_d;
  logic [7:0]  wrAddr_q;
  logic [31:0] hrdata_d;

  word_t       lutOut;
  word_t       regQ;
  word_t       zeroOut;
  word_t       oneOut;
  word_t       chainIn;
  word_t       bIn;

  ////////////////////////////////////////////////////////////////////////////
  wire         accept     = hsel & hready & (trans_t'(htrans) == TRANS_NONSEQ || trans_t'(htrans) == TRANS_SEQ);
  wire         readTake   = accept & ~hwrite;
  wire         writeTake  = accept & hwrite;
  wire [7:0]   rdAddr     = haddr[7:0];
  wire         addrHigh   = |haddr[31:8];
  wire         inWrite    = (bus_q == BUS_WRITE);
  wire         wrCtrl     = inWrite & (wrAddr_q == `OFS_CTRL);
  wire         wrOpA      = inWrite & (wrAddr_q == `OFS_OPA);
  wire         wrOpB      = inWrite & (wrAddr_q == `OFS_OPB);
  wire         wrLoad     = inWrite & (wrAddr_q == `OFS_LOAD);
  wire         wrCmd      = inWrite & (wrAddr_q == `OFS_CMD);
  wire         wrPair     = inWrite & (wrAddr_q == `OFS_PAIRSEL);

  wire         arithMode  = ctrl_q[`CTRL_ARITH];
  wire         subBit     = ctrl_q[`CTRL_SUB];
  wire         counterOn  = ctrl_q[`CTRL_COUNTER];
  wire         countUp    = ctrl_q[`CTRL_UP];
  wire         groupCarry = ctrl_q[`CTRL_GCARRY];
  wire start_t chainStart = ctrl_q[`CTRL_START_LSB +: 4];
  wire         subtract   = arithMode & (counterOn ? ~countUp : subBit);
  wire         lastZero   = zeroOut[`ELEM_COUNT-1];
  wire         lastOne    = oneOut[`ELEM_COUNT-1];
  wire         carryOut   = (subtract | groupCarry) ? lastOne : lastZero;
  wire [31:0]  resultWord = {6'h00, regQ, 6'h00, lutOut};
  wire [31:0]  statusWord = {30'h00000000, regQ[`ELEM_COUNT-1], carryOut};

  ////////////////////////////////////////////////////////////////////////////
  group_ctrl_if ctl ();

  assign ctl.arithMode   = arithMode;
  assign ctl.subtract    = subtract;
  assign ctl.shiftMode   = ctrl_q[`CTRL_SHIFT];
  assign ctl.counterMode = counterOn;
  assign ctl.countEnable = ctrl_q[`CTRL_CNT_ENA];
  assign ctl.groupCarry  = groupCarry;
  assign ctl.syncClear   = cmd_q[`CMD_SCLR];
  assign ctl.syncLoad    = cmd_q[`CMD_SLOAD];
  assign ctl.asyncClear  = cmd_q[`CMD_ACLR];
  assign ctl.asyncPreset = cmd_q[`CMD_APRE];
  assign ctl.enaFirst    = ctrl_q[`CTRL_ENA_FIRST];
  assign ctl.enaSecond   = ctrl_q[`CTRL_ENA_SECOND];

  ////////////////////////////////////////////////////////////////////////////
  // A counter adds one (two with the group carry set) or subtracts one at the chain start, its other B bits are zero.
  genvar gi;
  generate
    for (gi = 0; gi < `ELEM_COUNT; gi = gi + 1) begin : gElem
      wire zeroPrev;
      wire onePrev;
      if (gi == 0) begin : gFirst
        assign zeroPrev    = 1'b0;
        assign onePrev     = 1'b1;
        assign chainIn[gi] = ctrl_q[`CTRL_CHAIN_IN];
      end else begin : gRest
        assign zeroPrev    = zeroOut[gi-1];
        assign onePrev     = oneOut[gi-1];
        assign chainIn[gi] = regQ[gi-1];
      end
      assign bIn[gi] = (arithMode & counterOn) ? isStart(chainStart, gi) : opB_q[gi];
      logic_element uElem (
        .ref_clk             (ref_clk),
        .rst_n               (rst_n),
        .ctl                 (ctl),
        .inChain             (inRange(chainStart, gi)),
        .chainFirst          (isStart(chainStart, gi)),
        .pairSel             (pairSel_q[gi]),
        .operand_a_in        (opA_q[gi]),
        .operand_b_in        (bIn[gi]),
        .loadBit             (load_q[gi]),
        .carry_zero_path_in  (zeroPrev),
        .carry_one_path_in   (onePrev),
        .regChainIn          (chainIn[gi]),
        .lutOut              (lutOut[gi]),
        .carry_zero_path_out (zeroOut[gi]),
        .carry_one_path_out  (oneOut[gi]),
        .regQ                (regQ[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bus_d = BUS_IDLE;
    case (bus_q)
      BUS_IDLE:  bus_d = writeTake ? BUS_WRITE : BUS_IDLE;
      BUS_WRITE: bus_d = writeTake ? BUS_WRITE : BUS_IDLE;
      default:   bus_d = BUS_IDLE;
    endcase
  end

  assign ctrl_d    = wrCtrl ? (hwdata & `CTRL_MASK) : ctrl_q;
  assign opA_d     = wrOpA ? hwdata[9:0] : opA_q;
  assign opB_d     = wrOpB ? hwdata[9:0] : opB_q;
  assign load_d    = wrLoad ? hwdata[9:0] : load_q;
  assign pairSel_d = wrPair ? hwdata[9:0] : pairSel_q;
  assign cmd_d     = wrCmd ? hwdata[3:0] : 4'h0;

  always_comb begin
    hrdata_d = 32'h00000000;
    if (readTake && !addrHigh) begin
      case (rdAddr)
        `OFS_CTRL:    hrdata_d = ctrl_q;
        `OFS_OPA:     hrdata_d = {22'h000000, opA_q};
        `OFS_OPB:     hrdata_d = {22'h000000, opB_q};
        `OFS_LOAD:    hrdata_d = {22'h000000, load_q};
        `OFS_RESULT:  hrdata_d = resultWord;
        `OFS_STATUS:  hrdata_d = statusWord;
        `OFS_PAIRSEL: hrdata_d = {22'h000000, pairSel_q};
        default:      hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q    <= `CTRL_RESET;
      opA_q     <= 10'h000;
      opB_q     <= 10'h000;
      load_q    <= 10'h000;
      pairSel_q <= 10'h000;
      cmd_q     <= 4'h0;
    end else begin
      ctrl_q    <= ctrl_d;
      opA_q     <= opA_d;
      opB_q     <= opB_d;
      load_q    <= load_d;
      pairSel_q <= pairSel_d;
      cmd_q     <= cmd_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_q     <= BUS_IDLE;
      wrAddr_q  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      bus_q     <= bus_d;
      wrAddr_q  <= (writeTake && !addrHigh) ? haddr[7:0] : (writeTake ? 8'hFF : wrAddr_q);
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the datapath and the bus; plainArith covers the chain starting at the lowest element.
  wire plainArith = arithMode & ~counterOn & (chainStart == 4'h0);
  wire [10:0] addRef = {1'b0, opA_q} + {1'b0, opB_q} + {10'h000, groupCarry};
  wire [10:0] subRef = {1'b0, opA_q} + {1'b0, ~opB_q} + 11'h001;
  wire noCmd = (cmd_q == 4'h0);
  wire bothEna = ctrl_q[`CTRL_ENA_FIRST] & ctrl_q[`CTRL_ENA_SECOND];
  wire [4:0] upRef = {1'b0, opA_q[9:6]} + {1'b0, opB_q[9:6]} + 5'h01;

  sequence sReadCtrl;
    readTake && !addrHigh && (rdAddr == `OFS_CTRL);
  endsequence

  sequence sWriteCtrl;
    writeTake && !addrHigh && (haddr[7:0] == `OFS_CTRL) ##1 1'b1;
  endsequence

  a_add_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (plainArith && !subBit) |-> (lutOut == addRef[9:0]))
    else $error("sum does not match A plus B");
  a_sub_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (plainArith && subBit) |-> (lutOut == subRef[9:0]))
    else $error("difference does not match A minus B");
  a_carry_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (plainArith && !subBit) |-> (carryOut == addRef[10]))
    else $error("chain carry out wrong");
  a_normal_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !arithMode |-> (lutOut == (opA_q ^ opB_q)))
    else $error("normal mode result depends on subtract");
  a_mid_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arithMode && !counterOn && !subBit && groupCarry && chainStart == 4'h6)
      |-> (lutOut[9:6] == upRef[3:0]) && (lutOut[5:0] == (opA_q[5:0] ^ opB_q[5:0])))
    else $error("chain starting mid group computes wrong bits");
  a_sync_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_q == 4'h1 && bothEna) |=> (regQ == 10'h000))
    else $error("synchronous clear missed a register");
  a_sync_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_q == 4'h2 && bothEna) |=> (regQ == $past(load_q)))
    else $error("synchronous load missed a register");
  a_shift_chain: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_q[`CTRL_SHIFT] && bothEna && noCmd)
      |=> (regQ == {$past(regQ[8:0]), $past(ctrl_q[`CTRL_CHAIN_IN])}))
    else $error("register chain did not shift");
  a_reg_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ctrl_q[`CTRL_SHIFT] && !counterOn && bothEna && noCmd) |=> (regQ == $past(lutOut)))
    else $error("registered result differs from unregistered one");
  a_count_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (plainArith || (arithMode && counterOn && chainStart == 4'h0 && !ctrl_q[`CTRL_CNT_ENA]))
      && counterOn && !ctrl_q[`CTRL_SHIFT] && noCmd |=> $stable(regQ))
    else $error("counter moved while disabled");
  // Elements on the first clock pair must hold while that pair's enable is low.
  a_pair_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ctrl_q[`CTRL_ENA_FIRST] && noCmd) |=> ((regQ & ~$past(pairSel_q)) == $past(regQ & ~pairSel_q)))
    else $error("element ignored its paired enable");
  a_read_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sReadCtrl |=> (hrdata == $past(ctrl_q)))
    else $error("control read returned wrong data");
  a_write_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sWriteCtrl |=> (ctrl_q == ($past(hwdata) & `CTRL_MASK)))
    else $error("control write not stored");
  a_bus_okay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hreadyout) |-> (hresp == 1'b0) [*3])
    else $error("slave gave a non okay response");
endmodule : arith_slice_carry_select
`default_nettype wire

// >>> hdl/arith_slice_defines.svh
`ifndef ARITH_SLICE_DEFINES_SVH
`define ARITH_SLICE_DEFINES_SVH
`define ELEM_COUNT      10
`define OFS_CTRL        8'h00
`define OFS_OPA         8'h04
`define OFS_OPB         8'h08
`define OFS_LOAD        8'h0C
`define OFS_CMD         8'h10
`define OFS_RESULT      8'h14
`define OFS_STATUS      8'h18
`define OFS_PAIRSEL     8'h1C
`define CTRL_ARITH      0
`define CTRL_SUB        1
`define CTRL_ENA_FIRST  2
`define CTRL_ENA_SECOND 3
`define CTRL_SHIFT      4
`define CTRL_COUNTER    5
`define CTRL_CNT_ENA    6
`define CTRL_UP         7
`define CTRL_GCARRY     8
`define CTRL_CHAIN_IN   9
`define CTRL_START_LSB  12
`define CTRL_MASK       32'h0000F3FF
`define CTRL_RESET      32'h0000000C
`define CMD_SCLR        0
`define CMD_SLOAD       1
`define CMD_ACLR        2
`define CMD_APRE        3
`define RES_REG_LSB     16
`endif

// >>> hdl/arith_slice_pkg.sv
package arith_slice_pkg;
  typedef logic [9:0] word_t;
  typedef logic [3:0] start_t;
  typedef enum logic [1:0] {
    TRANS_IDLE   = 2'b00,
    TRANS_BUSY   = 2'b01,
    TRANS_NONSEQ = 2'b10,
    TRANS_SEQ    = 2'b11
  } trans_t;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01
  } bus_state_t;
endpackage : arith_slice_pkg

// >>> hdl/group_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface group_ctrl_if;
  logic arithMode;
  logic subtract;
  logic shiftMode;
  logic counterMode;
  logic countEnable;
  logic groupCarry;
  logic syncClear;
  logic syncLoad;
  logic asyncClear;
  logic asyncPreset;
  logic enaFirst;
  logic enaSecond;
  modport group (output arithMode, subtract, shiftMode, counterMode, countEnable, groupCarry,
                 syncClear, syncLoad, asyncClear, asyncPreset, enaFirst, enaSecond);
  modport element (input arithMode, subtract, shiftMode, counterMode, countEnable, groupCarry,
                   syncClear, syncLoad, asyncClear, asyncPreset, enaFirst, enaSecond);
endinterface : group_ctrl_if
`default_nettype wire

// >>> hdl/logic_element.sv
`timescale 1ns/1ps
`default_nettype none
module logic_element
  import arith_slice_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  group_ctrl_if.element ctl,
  input  wire logic   inChain,
  input  wire logic   chainFirst,
  input  wire logic   pairSel,
  input  wire logic   operand_a_in,
  input  wire logic   operand_b_in,
  input  wire logic   loadBit,
  input  wire logic   carry_zero_path_in,
  input  wire logic   carry_one_path_in,
  input  wire logic   regChainIn,
  output wire logic   lutOut,
  output wire logic   carry_zero_path_out,
  output wire logic   carry_one_path_out,
  output logic        regQ
);
  function automatic logic pick(input logic sel, input logic ifOne, input logic ifZero);
    pick = sel ? ifOne : ifZero;
  endfunction : pick

  logic regD;
  wire arith     = ctl.arithMode & inChain;
  wire opA       = (arith & ctl.counterMode) ? regQ : operand_a_in;
  wire condB     = operand_b_in ^ (arith & ctl.subtract);
  wire genZero   = opA & condB;
  wire genOne    = opA | condB;
  wire zeroIn    = chainFirst ? 1'b0 : carry_zero_path_in;
  wire oneIn     = chainFirst ? 1'b1 : carry_one_path_in;
  wire carrySel  = ctl.subtract | ctl.groupCarry;
  wire carryIn   = pick(carrySel, oneIn, zeroIn);
  wire clkOn     = pick(pairSel, ctl.enaSecond, ctl.enaFirst);
  wire countHold = arith & ctl.counterMode & ~ctl.countEnable;

  assign carry_zero_path_out = pick(zeroIn, genOne, genZero);
  assign carry_one_path_out  = pick(oneIn, genOne, genZero);
  assign lutOut = arith ? (opA ^ condB ^ carryIn) : (operand_a_in ^ operand_b_in);

  // Preset loads the load bit, so a tied-high load bit gives a plain preset.
  always_comb begin
    regD = regQ;
    if (ctl.asyncClear) regD = 1'b0;
    else if (ctl.asyncPreset) regD = loadBit;
    else if (clkOn) begin
      if (ctl.syncClear) regD = 1'b0;
      else if (ctl.syncLoad) regD = loadBit;
      else if (ctl.shiftMode) regD = regChainIn;
      else if (!countHold) regD = lutOut;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) regQ <= 1'b0;
    else regQ <= regD;
  end

  a_gate_stops: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!clkOn && !ctl.asyncClear && !ctl.asyncPreset) |=> $stable(regQ))
    else $error("register moved while its clock enable was low");
  a_async_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctl.asyncClear |=> !regQ)
    else $error("clear did not empty the register");
endmodule : logic_element
`default_nettype wire

// >>> verif/ahb_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model
  import arith_slice_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             timedOut
);
  initial begin
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = TRANS_IDLE;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    timedOut = 1'b0;
  end

  // Waits for hready at a rising edge; the bound stops a stalled slave from hanging the run.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 16) begin
      @(posedge ref_clk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      timedOut = 1'b1;
    end
  endtask : wait_ready

  task automatic transfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= TRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    htrans <= TRANS_IDLE;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
  endtask : transfer
endmodule : ahb_master_model
`default_nettype wire

// >>> verif/arith_slice_carry_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "arith_slice_defines.svh"
module arith_slice_carry_select_tb
  import arith_slice_pkg::*;
;
  logic        ref_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        timedOut;
  logic [31:0] rd;
  logic [31:0] ctrl;
  logic [10:0] res;
  word_t       a;
  word_t       b;
  word_t       oldReg;
  int          failures;
  int          numChecks;
  int          cycleCount;
  int          edgeStart;

  arith_slice_carry_select dut_u (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata)
  );

  ahb_master_model master_u (
    .ref_clk   (ref_clk),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .timedOut  (timedOut)
  );

  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever begin
      #5 ref_clk = ~ref_clk;
    end
  end

  always @(posedge ref_clk) begin
    cycleCount <= cycleCount + 1;
    if (timedOut === 1'b1) begin
      failures++;
      complete_run();
    end
  end

  ////////////////////////////////////////
  // Result bits [9:0] and, in arithmetic mode (c[0] set), the carry out of the top element in bit 10.
  function automatic logic [10:0] expect_sum(input logic [31:0] c, input word_t x, input word_t y);
    logic [10:0] r;
    logic        cy;
    logic        yb;
    int          s;
    s  = c[15:12];
    cy = c[1] | c[8];
    r  = '0;
    for (int i = 0; i < 10; i++) begin
      yb = y[i] ^ c[1];
      if (c[0] && i >= s) begin
        r[i] = x[i] ^ yb ^ cy;
        cy   = (x[i] & yb) | (x[i] & cy) | (yb & cy);
      end else begin
        r[i] = x[i] ^ y[i];
      end
    end
    r[10] = cy;
    return r;
  endfunction : expect_sum

  task automatic check_word(input string name, input logic [31:0] expVal, input logic [31:0] gotVal);
    numChecks++;
    if (gotVal !== expVal) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, expVal, gotVal);
    end
  endtask : check_word

  // One idle edge after each write lets a command pulse reach the element registers.
  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    master_u.transfer(1'b1, addr, data, rd);
    @(posedge ref_clk);
  endtask : wr

  task automatic read_check(input string name, input logic [31:0] addr, input logic [31:0] expVal,
                            input logic [31:0] mask = 32'hFFFFFFFF);
    master_u.transfer(1'b0, addr, 32'h0, rd);
    check_word(name, expVal & mask, rd & mask);
    check_word("hresp", 32'h0, {31'h0, hresp});
  endtask : read_check

  task automatic complete_run();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  initial begin
    rst_n      = 1'b0;
    failures   = 0;
    numChecks  = 0;
    cycleCount = 0;
    rd         = $urandom(32'h5D00FBDE);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    read_check("ctrl reset", `OFS_CTRL, `CTRL_RESET);
    read_check("regs reset", `OFS_RESULT, 32'h0);
    wr(`OFS_OPA, 32'hFFFFFFFF);
    read_check("opa width", `OFS_OPA, 32'h000003FF);
    wr(32'h00000020, 32'hFFFFFFFF);
    read_check("unmapped", 32'h00000020, 32'h0);
    read_check("cmd read", `OFS_CMD, 32'h0);
    for (int k = 0; k < 40; k++) begin
      a    = word_t'($urandom);
      b    = word_t'($urandom);
      ctrl = ($urandom & 32'h00000103) | 32'h0000000C | (32'($urandom_range(9, 0)) << 12);
      if (k == 0) begin
        a    = 10'h000;
        b    = 10'h001;
        ctrl = 32'h0000000F;
      end
      if (k == 1) begin
        a    = 10'h3FF;
        b    = 10'h001;
        ctrl = 32'h0000900D;
      end
      res = expect_sum(ctrl, a, b);
      wr(`OFS_OPA, {22'h0, a});
      wr(`OFS_OPB, {22'h0, b});
      wr(`OFS_CTRL, ctrl);
      if (ctrl[0]) begin
        read_check("carry out", `OFS_STATUS, {31'h0, res[10]}, 32'h1);
      end
      read_check("result", `OFS_RESULT, {6'h0, res[9:0], 6'h0, res[9:0]});
    end
    oldReg = res[9:0];
    wr(`OFS_PAIRSEL, 32'h000002AA);
    wr(`OFS_CTRL, 32'h00000009);
    wr(`OFS_OPA, {22'h0, ~a});
    res = expect_sum(32'h00000009, ~a, b);
    read_check("pair gate", `OFS_RESULT, {6'h0, (res[9:0] & 10'h2AA) | (oldReg & 10'h155), 6'h0, res[9:0]});
    wr(`OFS_CTRL, 32'h00000000);
    wr(`OFS_LOAD, 32'h000002C5);
    wr(`OFS_CMD, 32'h00000008);
    read_check("preset", `OFS_RESULT, 32'h02C50000, 32'h03FF0000);
    wr(`OFS_CMD, 32'h00000001);
    read_check("gated clear", `OFS_RESULT, 32'h02C50000, 32'h03FF0000);
    wr(`OFS_CMD, 32'h00000004);
    read_check("clear", `OFS_RESULT, 32'h0, 32'h03FF0000);
    wr(`OFS_CTRL, 32'h0000002D);
    wr(`OFS_CMD, 32'h00000002);
    read_check("sync load", `OFS_RESULT, 32'h02C50000, 32'h03FF0000);
    wr(`OFS_CMD, 32'h00000001);
    read_check("sync clear", `OFS_RESULT, 32'h0, 32'h03FF0000);
    wr(`OFS_CMD, 32'h00000002);
    wr(`OFS_CTRL, 32'h000000ED);
    edgeStart = cycleCount;
    wr(`OFS_CTRL, 32'h0000002D);
    oldReg = word_t'(32'h2C5 + cycleCount - edgeStart);
    read_check("count up", `OFS_RESULT, {6'h0, oldReg, 16'h0}, 32'h03FF0000);
    wr(`OFS_CTRL, 32'h0000006D);
    edgeStart = cycleCount;
    wr(`OFS_CTRL, 32'h0000002D);
    oldReg = word_t'(oldReg - (cycleCount - edgeStart));
    read_check("count down", `OFS_RESULT, {6'h0, oldReg, 16'h0}, 32'h03FF0000);
    wr(`OFS_CTRL, 32'h0000021C);
    repeat (12) @(posedge ref_clk);
    wr(`OFS_CTRL, 32'h0000001C);
    edgeStart = cycleCount;
    wr(`OFS_CTRL, 32'h00000000);
    oldReg = word_t'(10'h3FF << (cycleCount - edgeStart));
    read_check("shift", `OFS_RESULT, {6'h0, oldReg, 16'h0}, 32'h03FF0000);
    read_check("chain out", `OFS_STATUS, {30'h0, oldReg[9], 1'b0}, 32'h2);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    read_check("ctrl rereset", `OFS_CTRL, `CTRL_RESET);
    read_check("regs rereset", `OFS_RESULT, 32'h0);
    complete_run();
  end
endmodule : arith_slice_carry_select_tb
`default_nettype wire
